// file: hdl/motor_drive_protection_supervisor.sv
// Motor drive protection supervisor: mode machine, protection checks, PWM and events
`timescale 1ns/1ps
module motor_drive_protection_supervisor #(
   parameter int TICK_CYCLES_P = motor_sup_pkg::TICK_CYCLES
) (
   input  wire logic                     i_core_clk,
   input  wire logic                     i_reset,
   input  wire logic                     i_wb_cyc,
   input  wire logic                     i_wb_stb,
   input  wire logic                     i_wb_we,
   input  wire logic [7:0]               i_wb_adr,
   input  wire logic [31:0]              i_wb_dat,
   input  wire logic [3:0]               i_wb_sel,
   output      logic [31:0]              o_wb_dat,
   output      logic                     o_wb_ack,
   input  wire motor_sup_pkg::samples_s  i_samples,
   input  wire logic                     i_estop_n,
   output      motor_sup_pkg::pwm_s      o_pwm,
   output      motor_sup_pkg::mode_e     o_mode,
   output      motor_sup_pkg::ref_sel_s  o_ref_sel,
   output      logic                     o_irq
);
   import motor_sup_pkg::*;

   localparam logic [10:0] PEAK       = 11'(CARRIER_PEAK);
   localparam logic [15:0] TICK_LAST  = 16'(TICK_CYCLES_P - 1);

   mode_e            mode_r;
   mode_e            mode_nxt;
   logic             ack_r;
   logic [31:0]      rdat_r;
   logic [ST_W-1:0]  status_r;
   logic [ST_W-1:0]  mask_r;
   logic [ST_W-1:0]  cause_r;
   logic [2:0][11:0] vcmd_r;
   logic [2:0]       startup_r;
   logic [11:0]      vbus_r;
   logic [10:0]      car_r;
   logic             car_up_r;
   logic [15:0]      tick_cnt_r;
   logic [2:0][10:0] duty_r;
   logic [2:0][10:0] duty_nxt;
   logic [2:0]       phase_on_r;

   // Bus decode; writes land on the edge where the master sees ack
   wire        bus_req  = i_wb_cyc & i_wb_stb;
   wire        wr_en    = bus_req & i_wb_we & ack_r;
   wire        wr_cmd   = wr_en & (i_wb_adr == REG_CMD) & i_wb_sel[0];
   wire        wr_stat  = wr_en & (i_wb_adr == REG_STATUS) & i_wb_sel[0];
   wire        wr_mask  = wr_en & (i_wb_adr == REG_MASK) & i_wb_sel[0];
   wire        wr_start = wr_en & (i_wb_adr == REG_STARTUP) & i_wb_sel[0];
   wire [2:0]  wr_vcmd;
   assign wr_vcmd[0] = wr_en & (i_wb_adr == REG_VCMD_U);
   assign wr_vcmd[1] = wr_en & (i_wb_adr == REG_VCMD_V);
   assign wr_vcmd[2] = wr_en & (i_wb_adr == REG_VCMD_W);

   wire        run_cmd   = wr_cmd & i_wb_dat[CMD_RUN];
   wire        stop_cmd  = wr_cmd & i_wb_dat[CMD_STOP];
   wire        reset_cmd = wr_cmd & i_wb_dat[CMD_RESET];

   // Carrier crest is the overflow event and the 100 us check instant
   wire        car_tick  = car_up_r & (car_r == PEAK);
   wire        ms_tick   = (tick_cnt_r == TICK_LAST);

   // voltage scaled by the full-scale span, so thresholds stay exact integers
   wire [19:0] vbus_scaled = 20'(i_samples.vbus) * 20'(VBUS_FS_V);
   wire        ov_hit      = vbus_scaled > 20'(OV_LIM_SCALED);
   wire        uv_hit      = vbus_scaled < 20'(UV_LIM_SCALED);
   wire        os_hit      = i_samples.speed_rpm > 16'(OS_LIMIT_RPM);
   logic       oc_hit;

   // clamp to the highest attainable code, then compare magnitude in 0.01 A units
   always_comb
   begin
      logic [11:0] code;
      logic [24:0] diff;
      code   = 12'h000;
      diff   = 25'h000_0000;
      oc_hit = 1'b0;
      for (int p = 0; p < 3; p++)
      begin
         code = (i_samples.iph[p] > 12'(CUR_MAX_CODE)) ? 12'(CUR_MAX_CODE)
                                                      : i_samples.iph[p];
         diff = 25'(code) * 25'(CUR_SPAN_X100) - 25'(CUR_OFFS_SCALED);
         if (diff[24])
            diff = 25'(0) - diff;
         if (diff > 25'(OC_LIM_SCALED))
            oc_hit = 1'b1;
      end
   end

   // protection checks act only at the 100 us instant; tick and emergency events are not gated by it
   wire [ST_W-1:0] chk_evt;
   assign chk_evt[ST_OC]    = car_tick & oc_hit;
   assign chk_evt[ST_OV]    = car_tick & ov_hit;
   assign chk_evt[ST_UV]    = car_tick & uv_hit;
   assign chk_evt[ST_OS]    = car_tick & os_hit;
   assign chk_evt[ST_CAR]   = car_tick;
   assign chk_evt[ST_TICK]  = ms_tick;
   assign chk_evt[ST_ESTOP] = ~i_estop_n;
   // fault raised internally by any check
   wire   fault_evt = |chk_evt[ST_OS:ST_OC];

   // mode transitions; a fault outranks any command in the same cycle
   always_comb
   begin
      mode_nxt = mode_r;
      unique case (mode_r)
         drive_stopped_mode:
         begin
            if (fault_evt)
               mode_nxt = fault_mode;
            else if (run_cmd)
               mode_nxt = drive_running_mode;
         end
         drive_running_mode:
         begin
            if (fault_evt)
               mode_nxt = fault_mode;
            else if (stop_cmd)
               mode_nxt = drive_stopped_mode;
         end
         fault_mode:
         begin
            if (reset_cmd && !fault_evt)
               mode_nxt = drive_stopped_mode;
         end
         default:
            mode_nxt = fault_mode;
      endcase
   end

   // single mode register for this channel
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
         mode_r <= drive_stopped_mode;
      else
         mode_r <= mode_nxt;
   end

   // Triangular carrier, 0 up to peak and back, one full period per 100 us
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         car_r    <= 11'h000;
         car_up_r <= 1'b1;
      end
      else
      begin
         if (car_up_r)
            car_r <= (car_r == PEAK) ? car_r - 11'h001 : car_r + 11'h001;
         else
            car_r <= (car_r == 11'h000) ? car_r + 11'h001 : car_r - 11'h001;
         if ((car_up_r && car_r == PEAK) || (!car_up_r && car_r == 11'h000))
            car_up_r <= ~car_up_r;
      end
   end

   // Free-running 1 ms tick
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
         tick_cnt_r <= 16'h0000;
      else
         tick_cnt_r <= ms_tick ? 16'h0000 : tick_cnt_r + 16'h0001;
   end

   // modulation factor times carrier peak; saturates at full duty
   always_comb
   begin
      logic [22:0] quo;
      quo      = 23'h00_0000;
      duty_nxt = '0;
      for (int p = 0; p < 3; p++)
      begin
         if (vbus_r == 12'h000)
            quo = 23'h00_0000;
         else
            quo = (23'(vcmd_r[p]) * 23'(CARRIER_PEAK)) / 23'(vbus_r);
         duty_nxt[p] = (quo > 23'(CARRIER_PEAK)) ? PEAK : quo[10:0];
      end
   end

   // bus sample and duty registers refresh at the crest, so a period stays whole
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         vbus_r <= 12'h000;
         duty_r <= '0;
      end
      else if (car_tick)
      begin
         vbus_r <= i_samples.vbus;
         duty_r <= duty_nxt;
      end
   end

   // phase on while the command level exceeds the carrier
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
         phase_on_r <= 3'h0;
      else
         for (int p = 0; p < 3; p++)
            phase_on_r[p] <= duty_r[p] > car_r;
   end

   // Upper pins are high while the phase is on, lower pins are their complement; no dead time is inserted here
   assign o_pwm.level = {phase_on_r, ~phase_on_r};
   // pins float on emergency input or whenever this channel is not running
   assign o_pwm.oe    = {6{i_estop_n & (mode_r == drive_running_mode)}};
   assign o_mode      = mode_r;

   // Software registers; status set wins over a same-cycle clear
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         status_r  <= '0;
         mask_r    <= MASK_RST;
         vcmd_r    <= {3{VCMD_RST}};
         startup_r <= STARTUP_RST;
         cause_r   <= '0;
      end
      else
      begin
         status_r <= (status_r & ~(wr_stat ? i_wb_dat[ST_W-1:0] : '0)) | chk_evt;
         if (wr_mask)
            mask_r <= i_wb_dat[ST_W-1:0];
         if (wr_start)
            startup_r <= i_wb_dat[2:0];
         for (int p = 0; p < 3; p++)
         begin
            if (wr_vcmd[p] && i_wb_sel[0])
               vcmd_r[p][7:0] <= i_wb_dat[7:0];
            if (wr_vcmd[p] && i_wb_sel[1])
               vcmd_r[p][11:8] <= i_wb_dat[11:8];
         end
         if (fault_evt && mode_r != fault_mode)
            cause_r <= chk_evt;
      end
   end

   // start-up reference source flags, driven only while running
   assign o_ref_sel.id_src  = startup_r[0] & (mode_r == drive_running_mode);
   assign o_ref_sel.iq_src  = startup_r[1] & (mode_r == drive_running_mode);
   assign o_ref_sel.spd_src = startup_r[2] & (mode_r == drive_running_mode);

   // Pending unmasked events and the most urgent level among the fault, carrier and tick events
   wire [ST_W-1:0] pend = status_r & mask_r;
   logic [3:0]     prio_lvl;
   assign prio_lvl = (|pend[ST_OS:ST_OC]) ? PRIO_FAULT :
                     pend[ST_CAR]         ? PRIO_CARRIER :
                     pend[ST_TICK]        ? PRIO_TICK : PRIO_MIN;
   assign o_irq    = |pend;

   // Read mux; unmapped addresses read zero and still ack
   logic [31:0] rmux;
   always_comb
   begin
      rmux = 32'h0000_0000;
      unique case (i_wb_adr)
         REG_CMD:     rmux = {30'h0000_0000, mode_r};
         REG_STATUS:  rmux = {25'h000_0000, status_r};
         REG_MASK:    rmux = {25'h000_0000, mask_r};
         REG_VCMD_U:  rmux = {20'h0_0000, vcmd_r[0]};
         REG_VCMD_V:  rmux = {20'h0_0000, vcmd_r[1]};
         REG_VCMD_W:  rmux = {20'h0_0000, vcmd_r[2]};
         REG_STARTUP: rmux = {29'h0000_0000, startup_r};
         REG_PRIO:    rmux = {28'h000_0000, prio_lvl};
         REG_VBUS:    rmux = {20'h0_0000, vbus_r};
         REG_CAUSE:   rmux = {25'h000_0000, cause_r};
         default:     rmux = 32'h0000_0000;
      endcase
   end

   // One wait state: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r  <= bus_req & ~ack_r;
         rdat_r <= rmux;
      end
   end
   assign o_wb_ack = ack_r;
   assign o_wb_dat = rdat_r;

   property p_mode_legal;
      @(posedge i_core_clk) disable iff (i_reset)
      mode_r inside {drive_stopped_mode, drive_running_mode, fault_mode};
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("illegal mode");

   property p_run_start;
      @(posedge i_core_clk) disable iff (i_reset)
      (mode_r == drive_stopped_mode && run_cmd && !fault_evt) |=> mode_r == drive_running_mode;
   endproperty
   a_run_start: assert property (p_run_start) else $error("run not taken");

   property p_fault_hold;
      @(posedge i_core_clk) disable iff (i_reset)
      (mode_r == fault_mode && !reset_cmd) |=> mode_r == fault_mode;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault left early");

   property p_estop_hiz;
      @(posedge i_core_clk) disable iff (i_reset)
      !i_estop_n |-> o_pwm.oe == 6'h00;
   endproperty
   a_estop_hiz: assert property (p_estop_hiz) else $error("pins driven in stop");

   property p_oc_fault;
      @(posedge i_core_clk) disable iff (i_reset)
      (car_tick && oc_hit) |=> mode_r == fault_mode ##1 o_pwm.oe == 6'h00;
   endproperty
   a_oc_fault: assert property (p_oc_fault) else $error("overcurrent ignored");

   property p_volt_fault;
      @(posedge i_core_clk) disable iff (i_reset)
      (car_tick && (ov_hit || uv_hit)) |=> mode_r == fault_mode;
   endproperty
   a_volt_fault: assert property (p_volt_fault) else $error("voltage fault ignored");

   property p_os_fault;
      @(posedge i_core_clk) disable iff (i_reset)
      (car_tick && os_hit && mode_r != fault_mode) |=> mode_r == fault_mode && cause_r[ST_OS];
   endproperty
   a_os_fault: assert property (p_os_fault) else $error("overspeed ignored");

   property p_tick_spacing;
      @(posedge i_core_clk) disable iff (i_reset)
      car_tick |=> !car_tick [*8];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("crest too soon");

   property p_compare;
      @(posedge i_core_clk) disable iff (i_reset)
      ##1 o_pwm.level[0] == ($past(duty_r[0]) <= $past(car_r));
   endproperty
   a_compare: assert property (p_compare) else $error("carrier compare wrong");

   property p_prio;
      @(posedge i_core_clk) disable iff (i_reset)
      pend[ST_OC] |-> prio_lvl == 4'h0 && o_irq;
   endproperty
   a_prio: assert property (p_prio) else $error("fault not top level");

   property p_ack_pulse;
      @(posedge i_core_clk) disable iff (i_reset)
      ack_r |=> !ack_r;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
endmodule

// file: hdl/motor_sup_pkg.sv
// Constants, register map and port types of the motor drive protection supervisor
package motor_sup_pkg;
   // Clock and carrier timing
   localparam int CLK_MHZ           = 40;
   localparam int CARRIER_PERIOD_US = 100;
   localparam int CARRIER_CYCLES    = CARRIER_PERIOD_US * CLK_MHZ;
   localparam int CARRIER_PEAK      = CARRIER_CYCLES / 2;
   localparam int TICK_PERIOD_MS    = 1;
   localparam int TICK_CYCLES       = TICK_PERIOD_MS * 1000 * CLK_MHZ;

   // Converter scaling: full-scale code and physical spans
   localparam int ADC_FS_CODE       = 32'h0000_0FFF;
   localparam int CUR_MAX_CODE      = 32'h0000_0E8B;
   localparam int VBUS_FS_V         = 111;
   localparam int CUR_SPAN_X100     = 2500;
   localparam int CUR_NEG_X100      = 1250;

   // Protection thresholds
   localparam int OC_LIMIT_X100     = 89;
   localparam int OV_LIMIT_V        = 28;
   localparam int UV_LIMIT_V        = 14;
   localparam int OS_LIMIT_RPM      = 3000;
   localparam int CUR_OFFS_SCALED   = CUR_NEG_X100 * ADC_FS_CODE;
   localparam int OC_LIM_SCALED     = OC_LIMIT_X100 * ADC_FS_CODE;
   localparam int OV_LIM_SCALED     = OV_LIMIT_V * ADC_FS_CODE;
   localparam int UV_LIM_SCALED     = UV_LIMIT_V * ADC_FS_CODE;

   // Event priority levels, 0 highest
   localparam logic [3:0] PRIO_FAULT   = 4'h0;
   localparam logic [3:0] PRIO_CARRIER = 4'h5;
   localparam logic [3:0] PRIO_TICK    = 4'hA;
   localparam logic [3:0] PRIO_MIN     = 4'hF;

   // Register byte offsets
   localparam logic [7:0] REG_CMD     = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_MASK    = 8'h08;
   localparam logic [7:0] REG_VCMD_U  = 8'h0C;
   localparam logic [7:0] REG_VCMD_V  = 8'h10;
   localparam logic [7:0] REG_VCMD_W  = 8'h14;
   localparam logic [7:0] REG_STARTUP = 8'h18;
   localparam logic [7:0] REG_PRIO    = 8'h1C;
   localparam logic [7:0] REG_VBUS    = 8'h20;
   localparam logic [7:0] REG_CAUSE   = 8'h24;

   // Command bits and status bit positions
   localparam int CMD_RUN   = 0;
   localparam int CMD_STOP  = 1;
   localparam int CMD_RESET = 2;
   localparam int ST_OC     = 0;
   localparam int ST_OV     = 1;
   localparam int ST_UV     = 2;
   localparam int ST_OS     = 3;
   localparam int ST_CAR    = 4;
   localparam int ST_TICK   = 5;
   localparam int ST_ESTOP  = 6;
   localparam int ST_W      = 7;

   // Reset values
   localparam logic [ST_W-1:0] MASK_RST    = 7'h00;
   localparam logic [11:0]     VCMD_RST    = 12'h000;
   localparam logic [2:0]      STARTUP_RST = 3'h0;

   typedef enum logic [1:0] {
      drive_stopped_mode = 2'b00,
      drive_running_mode = 2'b01,
      fault_mode         = 2'b10
   } mode_e;

   typedef struct packed {
      logic [11:0]      vbus;
      logic [2:0][11:0] iph;
      logic [15:0]      speed_rpm;
   } samples_s;

   typedef struct packed {
      logic [5:0] level;
      logic [5:0] oe;
   } pwm_s;

   typedef struct packed {
      logic id_src;
      logic iq_src;
      logic spd_src;
   } ref_sel_s;
endpackage

// file: tb/inverter_model.sv
// Behavioural inverter power stage with bus voltage and phase current sensing
`timescale 1ns/1ps
module inverter_model (
   input  wire motor_sup_pkg::pwm_s     i_pwm,
   input  wire logic signed [31:0]      i_vbus_mv,
   input  wire logic signed [2:0][15:0] i_cur_ma,
   input  wire logic signed [31:0]      i_rpm,
   output      motor_sup_pkg::samples_s o_samples
);
   import motor_sup_pkg::*;
   int c;

   // Sensing front end; a tri-stated bridge carries no phase current
   always_comb
   begin
      // bus code linear up to full scale
      o_samples.vbus = 12'(i_vbus_mv * ADC_FS_CODE / (VBUS_FS_V * 1000));
      o_samples.speed_rpm = 16'(i_rpm);
      for (int p = 0; p < 3; p++)
      begin
         c = (i_pwm.oe == 6'h00) ? 0 : int'($signed(i_cur_ma[p]));
         // offset linear code, clipped by level shift
         c = (c + CUR_NEG_X100 * 10) * ADC_FS_CODE / (CUR_SPAN_X100 * 10);
         o_samples.iph[p] = (c > CUR_MAX_CODE) ? 12'(CUR_MAX_CODE) : 12'(c);
      end
   end
endmodule

// file: tb/motor_drive_protection_supervisor_tb.sv
// Self-checking bench for the motor drive protection supervisor
`timescale 1ns/1ps
module motor_drive_protection_supervisor_tb;
   import motor_sup_pkg::*;
   localparam int          VB  = 24000 * ADC_FS_CODE / (VBUS_FS_V * 1000);
   localparam int          DW  = (VB / 2) * CARRIER_PEAK / VB;
   localparam int          NF  = 7;
   localparam logic [31:0] RUN = 32'h0000_0001 << CMD_RUN;
   localparam logic [31:0] STP = 32'h0000_0001 << CMD_STOP;
   localparam logic [31:0] RST = 32'h0000_0001 << CMD_RESET;
   logic                    i_core_clk = 1'b0;
   logic                    i_reset    = 1'b1;
   logic                    cyc        = 1'b0;
   logic                    stb        = 1'b0;
   logic                    we         = 1'b0;
   logic [7:0]              adr        = 8'h00;
   logic [31:0]             wdat       = 32'h0000_0000;
   logic [3:0]              sel        = 4'h0;
   logic [31:0]             rdat;
   logic                    ack;
   logic                    estop_n    = 1'b1;
   samples_s                samp;
   pwm_s                    pwm;
   mode_e                   mode;
   ref_sel_s                refs;
   logic                    irq;
   logic signed [31:0]      vbus_mv    = 24000;
   logic signed [2:0][15:0] cur_ma     = '0;
   logic signed [31:0]      rpm        = 1000;
   int                      errors     = 0;
   int                      n_tests    = 0;
   int                      seed       = 32'h10fa;
   int                      on [3];
   int                      bad;
   logic [2:0]              v;
   logic [31:0]             exp_q [$];
   string                   name_q [$];
   int f_mv  [NF] = '{28200, 13900, 24000, 24000, 24000, 27900, 14200};
   int f_ma  [NF] = '{0, 0, 1000, -1000, 0, 800, -800};
   int f_rpm [NF] = '{1000, 1000, 1000, 1000, 3001, 3000, 0};
   int f_bit [NF] = '{ST_OV, ST_UV, ST_OC, ST_OC, ST_OS, -1, -1};

   // 40 MHz core clock
   always #12.5 i_core_clk = ~i_core_clk;

   motor_drive_protection_supervisor #(.TICK_CYCLES_P(200)) dut_u (
      .i_core_clk(i_core_clk), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_samples(samp), .i_estop_n(estop_n), .o_pwm(pwm),
      .o_mode(mode), .o_ref_sel(refs), .o_irq(irq)
   );

   inverter_model model_u (
      .i_pwm(pwm), .i_vbus_mv(vbus_mv), .i_cur_ma(cur_ma),
      .i_rpm(rpm), .o_samples(samp)
   );

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_tests++;
      if (seen !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
   endtask

   // commands reach the block only over this bus
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      // Hold the request until ack is sampled; only the bound ends a hang
      do
      begin
         @(posedge i_core_clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
         check("ack", {31'h0, ack}, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      exp_q.push_back(e);
      name_q.push_back(nm);
      bus(a, 1'b0, 32'h0000_0000);
   endtask

   // Let launched updates land before looking at the ports
   task automatic idle(input int k);
      repeat (k) @(posedge i_core_clk);
      @(negedge i_core_clk);
   endtask

   // Whole current vector built first so each input gets one assignment per edge
   task automatic env(input int mv, input int ph, input int ma, input int r);
      logic signed [2:0][15:0] cm;
      cm = '0;
      cm[ph] = 16'(ma);
      @(posedge i_core_clk);
      vbus_mv <= mv;
      cur_ma <= cm;
      rpm <= r;
   endtask

   function automatic logic near(input int a, input int b);
      return (a - b <= 2) && (b - a <= 2);
   endfunction

   // Each read result is matched against the oldest note
   always @(posedge i_core_clk)
   begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
         check(name_q.pop_front(), rdat, exp_q.pop_front());
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog, about twice the planned run
   initial
   begin
      repeat (90000) @(posedge i_core_clk);
      errors++;
      conclude();
   end

   initial
   begin
      repeat (6) @(posedge i_core_clk);
      i_reset <= 1'b0;
      idle(1);
      check("mode", 32'(mode), 32'(drive_stopped_mode));
      check("oe", 32'(pwm.oe), 32'h0);
      rd(REG_CMD, 32'h0, "cmd");
      rd(REG_MASK, 32'(MASK_RST), "mask");
      rd(REG_VCMD_U, 32'(VCMD_RST), "vcmd_u");
      rd(REG_STARTUP, 32'(STARTUP_RST), "startup");
      wr(8'h30, 32'hffff_ffff);
      rd(8'h30, 32'h0, "unmapped");
      $display("test reset done");
      // Run, random start-up flags, stop, run again
      wr(REG_CMD, RUN);
      idle(2);
      check("mode", 32'(mode), 32'(drive_running_mode));
      check("oe", 32'(pwm.oe), 32'h3f);
      for (int k = 0; k < 4; k++)
      begin
         v = 3'($random(seed));
         wr(REG_STARTUP, {29'h0, v});
         idle(2);
         check("ref_sel", 32'(refs), {29'h0, v[0], v[1], v[2]});
      end
      wr(REG_CMD, STP);
      idle(2);
      check("mode", 32'(mode), 32'(drive_stopped_mode));
      check("ref_sel", 32'(refs), 32'h0);
      wr(REG_CMD, RUN);
      $display("test mode done");
      // Emergency input with its interrupt masked in
      wr(REG_MASK, 32'h1 << ST_ESTOP);
      wr(REG_STATUS, 32'h7f);
      idle(1);
      check("irq", {31'h0, irq}, 32'h0);
      @(posedge i_core_clk);
      estop_n <= 1'b0;
      @(negedge i_core_clk);
      check("oe", 32'(pwm.oe), 32'h0);
      idle(2);
      check("irq", {31'h0, irq}, 32'h1);
      check("mode", 32'(mode), 32'(drive_running_mode));
      @(posedge i_core_clk);
      estop_n <= 1'b1;
      idle(1);
      check("oe", 32'(pwm.oe), 32'h3f);
      wr(REG_STATUS, 32'h1 << ST_ESTOP);
      idle(1);
      check("irq", {31'h0, irq}, 32'h0);
      $display("test estop done");
      // Full, zero and half command against the carrier over one period
      wr(REG_VCMD_U, 32'(VB));
      wr(REG_VCMD_V, 32'h0);
      wr(REG_VCMD_W, 32'(VB / 2));
      // Duty uses the bus sample of the previous crest, so it settles after two crests
      idle(2 * CARRIER_CYCLES + 100);
      rd(REG_VBUS, 32'(VB), "vbus");
      on = '{0, 0, 0};
      bad = 0;
      for (int k = 0; k < CARRIER_CYCLES; k++)
      begin
         @(negedge i_core_clk);
         for (int p = 0; p < 3; p++)
         begin
            on[p] += pwm.level[3 + p];
            bad += (pwm.level[3 + p] == pwm.level[p]);
         end
      end
      check("on_u", 32'(near(on[0], 2 * CARRIER_PEAK - 1)), 32'h1);
      check("on_v", 32'(on[1]), 32'h0);
      check("on_w", 32'(near(on[2], 2 * DW - 1)), 32'h1);
      check("pair", 32'(bad), 32'h0);
      $display("test pwm done");
      // Each fault source, then values just inside the limits
      wr(REG_MASK, 32'h0f);
      for (int k = 0; k < NF; k++)
      begin
         env(f_mv[k], k % 3, f_ma[k], f_rpm[k]);
         idle(CARRIER_CYCLES + 100);
         env(24000, 0, 0, 1000);
         if (f_bit[k] < 0)
            check("mode", 32'(mode), 32'(drive_running_mode));
         else
         begin
            check("mode", 32'(mode), 32'(fault_mode));
            check("oe", 32'(pwm.oe), 32'h0);
            check("irq", {31'h0, irq}, 32'h1);
            // The crest event is latched together with the fault that it found
            rd(REG_CAUSE, (32'h1 << f_bit[k]) | (32'h1 << ST_CAR), "cause");
            rd(REG_PRIO, 32'(PRIO_FAULT), "prio");
            wr(REG_CMD, RUN);
            idle(2);
            check("mode", 32'(mode), 32'(fault_mode));
            wr(REG_CMD, RST);
            idle(2);
            check("mode", 32'(mode), 32'(drive_stopped_mode));
            wr(REG_STATUS, 32'h7f);
            wr(REG_CMD, RUN);
         end
      end
      $display("test faults done");
      // Event levels with only carrier and tick pending
      idle(CARRIER_CYCLES);
      wr(REG_MASK, 32'h1 << ST_TICK);
      rd(REG_PRIO, 32'(PRIO_TICK), "prio");
      idle(1);
      check("irq", {31'h0, irq}, 32'h1);
      wr(REG_MASK, (32'h1 << ST_TICK) | (32'h1 << ST_CAR));
      rd(REG_PRIO, 32'(PRIO_CARRIER), "prio");
      wr(REG_MASK, 32'h0);
      rd(REG_PRIO, 32'(PRIO_MIN), "prio");
      idle(1);
      check("irq", {31'h0, irq}, 32'h0);
      $display("test priority done");
      conclude();
   end
endmodule
